// >>> rtl/pcr_crossbar.sv
`timescale 1ns/1ns
// Overview of operation
// - edge capture on digital pins only
// - fixed rank order, uart highest
// - others take lowest free pin
// - uart fixed on P0.4 and P0.5
// - can fixed on P0.6 and P0.7
// - assigned pins excluded from later picks
// - skipped pins treated as taken
// - paired peripherals claim both pins
// - unclaimed pins stay general purpose
// - spi select pin only in 4-wire
// - input mode 1 digital, 0 analog
// - reset leaves all pins digital input
// - analog pins: no pullup, driver, receiver
// - output mode per pin, smbus open-drain
// - pullup on open-drain unless disabled
// - pullup off while driving low
// - crossbar off ignores routing
// - crossbar off disables all drivers
// - push-pull both rails, else low only
// - analog reads 0, digital reads pad
// - capture pins enabled cumulatively
module pcr_crossbar (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pcr_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [pcr_pkg::WB_SELW-1:0] wb_sel_i,
  input wire logic [pcr_pkg::WB_DW-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [pcr_pkg::WB_DW-1:0] wb_dat_o,
  input wire logic [pcr_pkg::NUM_RES-1:0] periph_out_i,
  input wire logic [pcr_pkg::NUM_RES-1:0] periph_oe_i,
  output logic [pcr_pkg::NUM_RES-1:0] periph_in_o,
  input wire logic [pcr_pkg::NUM_PINS-1:0] pad_in_i,
  output logic [pcr_pkg::NUM_PINS-1:0] pad_out_o,
  output logic [pcr_pkg::NUM_PINS-1:0] pad_oe_o,
  output logic [pcr_pkg::NUM_PINS-1:0] pad_pullup_o,
  output logic [pcr_pkg::NUM_PINS-1:0] pad_rx_en_o,
  output logic event_pending_o
);
  import pcr_pkg::*;

  function automatic logic hit(input logic [WB_AW-1:0] a,
                               input logic [WB_AW-1:0] o);
    return a[WB_AW-1:2] == o[WB_AW-1:2];
  endfunction

  function automatic logic [WB_DW-1:0] merge(
      input logic [WB_DW-1:0] old,
      input logic [WB_DW-1:0] nw,
      input logic [WB_SELW-1:0] sel);
    logic [WB_DW-1:0] r;
    r = old;
    for (int i = 0; i < WB_SELW; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [NUM_PINS-1:0] lowest_one(
      input logic [NUM_PINS-1:0] v);
    return v & (~v + NUM_PINS'(1));
  endfunction

  function automatic int fixed_pin(input int k);
    int r;
    r = -1;
    if (k == R_UART_TX) r = PIN_UART_TX;
    if (k == R_UART_RX) r = PIN_UART_RX;
    if (k == R_CAN_TX) r = PIN_CAN_TX;
    if (k == R_CAN_RX) r = PIN_CAN_RX;
    return r;
  endfunction

  logic ack_r;
  logic [WB_DW-1:0] dat_r;
  logic [7:0] route_a_r;
  logic [7:0] route_b_r;
  logic [7:0] route_c_r;
  logic [1:0] ss_mode_r;
  logic [NUM_PINS-1:0] in_mode_r;
  logic [NUM_PINS-1:0] out_mode_r;
  logic [NUM_PINS-1:0] skip_r;
  logic [NUM_PINS-1:0] gpio_out_r;
  logic [NUM_PINS-1:0] evt_mask_r;
  logic [NUM_PINS-1:0] evt_flag_r;
  logic [NUM_PINS-1:0] sync1_r;
  logic [NUM_PINS-1:0] sync2_r;
  logic [NUM_PINS-1:0] sync3_r;
  logic [NUM_PINS-1:0] stable_r;
  logic [NUM_PINS-1:0] prev_r;
  logic [NUM_PINS-1:0] route_r [NUM_RES];
  logic [NUM_PINS-1:0] out_r;
  logic [NUM_PINS-1:0] oe_r;
  logic [NUM_PINS-1:0] pullup_r;
  logic [NUM_PINS-1:0] rx_en_r;
  logic [NUM_RES-1:0] pin_in_r;
  logic evt_pend_r;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i;
  wire hit_a = hit(wb_adr_i, OFS_ROUTE_A);
  wire hit_b = hit(wb_adr_i, OFS_ROUTE_B);
  wire hit_c = hit(wb_adr_i, OFS_ROUTE_C);
  wire hit_ss = hit(wb_adr_i, OFS_SPI_CTL);
  wire hit_im = hit(wb_adr_i, OFS_IN_MODE);
  wire hit_om = hit(wb_adr_i, OFS_OUT_MODE);
  wire hit_sk = hit(wb_adr_i, OFS_SKIP);
  wire hit_go = hit(wb_adr_i, OFS_GPIO_OUT);
  wire hit_pr = hit(wb_adr_i, OFS_PAD_READ);
  wire hit_em = hit(wb_adr_i, OFS_EVT_MASK);
  wire hit_ef = hit(wb_adr_i, OFS_EVT_FLAG);
  wire [7:0] wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  wire wlow = wr & wb_sel_i[0];
  wire [WB_DW-1:0] wmask = merge(ZERO_WORD, wb_dat_i, wb_sel_i);

  // analog pins read back 0, digital pins the pad
  wire [NUM_PINS-1:0] pad_read = stable_r & in_mode_r;

  wire [WB_DW-1:0] rdata =
    hit_a ? {24'h000000, route_a_r} :
    hit_b ? {24'h000000, route_b_r} :
    hit_c ? {24'h000000, route_c_r} :
    hit_ss ? {28'h0000000, ss_mode_r, 2'h0} :
    hit_im ? in_mode_r :
    hit_om ? out_mode_r :
    hit_sk ? skip_r :
    hit_go ? gpio_out_r :
    hit_pr ? pad_read :
    hit_em ? evt_mask_r :
    hit_ef ? evt_flag_r : ZERO_WORD;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
      dat_r <= ZERO_WORD;
    end else if (ce_i) begin
      ack_r <= req;
      dat_r <= req ? rdata : dat_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_a_r <= ROUTE_RST;
      route_b_r <= ROUTE_RST;
      route_c_r <= ROUTE_RST;
      ss_mode_r <= SS_RST;
      in_mode_r <= IN_MODE_RST;
      out_mode_r <= OUT_MODE_RST;
      skip_r <= SKIP_RST;
      gpio_out_r <= GPIO_OUT_RST;
      evt_mask_r <= ZERO_PINS;
    end else if (ce_i) begin
      if (wlow && hit_a) route_a_r <= wbyte;
      if (wlow && hit_b) route_b_r <= wbyte;
      if (wlow && hit_c) route_c_r <= wbyte;
      if (wlow && hit_ss) ss_mode_r <= wbyte[SS_HI:SS_LO];
      if (wr && hit_im) in_mode_r <= merge(in_mode_r, wb_dat_i, wb_sel_i);
      if (wr && hit_om) out_mode_r <= merge(out_mode_r, wb_dat_i, wb_sel_i);
      if (wr && hit_sk) skip_r <= merge(skip_r, wb_dat_i, wb_sel_i);
      if (wr && hit_go) gpio_out_r <= merge(gpio_out_r, wb_dat_i, wb_sel_i);
      if (wr && hit_em) evt_mask_r <= merge(evt_mask_r, wb_dat_i, wb_sel_i);
    end
  end

  // resource enables; routing is inert until the crossbar is on
  wire xbar = route_c_r[RC_XBAR];
  wire wpud = route_c_r[RC_WPUD];
  wire [2:0] pca = route_b_r[RB_PCA_HI:RB_PCA_LO];
  wire four_wire = ss_mode_r != SS_3WIRE;
  logic [NUM_RES-1:0] en;

  assign en[R_UART_TX] = xbar & route_a_r[RA_UART];
  assign en[R_UART_RX] = xbar & route_a_r[RA_UART];
  assign en[R_SPI_NSS-1:R_SPI_SCK] = {3{xbar & route_a_r[RA_SPI]}};
  assign en[R_SPI_NSS] = xbar & route_a_r[RA_SPI] & four_wire;
  assign en[R_SMB_SDA] = xbar & route_a_r[RA_SMB];
  assign en[R_SMB_SCL] = xbar & route_a_r[RA_SMB];
  assign en[R_CAN_TX] = xbar & route_a_r[RA_CAN];
  assign en[R_CAN_RX] = xbar & route_a_r[RA_CAN];
  assign en[R_SYSCLK-1:R_CP0] = {4{xbar}} & route_a_r[7:RA_CP0];
  assign en[R_SYSCLK] = xbar & route_b_r[RB_SYSCLK];
  assign en[R_LIN_TX-1:R_ECI] = {3{xbar}} & route_b_r[7:RB_ECI];
  assign en[R_LIN_TX] = xbar & route_c_r[RC_LIN];
  assign en[R_LIN_RX] = xbar & route_c_r[RC_LIN];

  // reserved pca code routes nothing
  genvar k, p;
  generate
    for (k = 0; k < NUM_CEX; k++) begin : g_cex
      assign en[R_CAPTURE_COMPARE_PIN_0+k] = xbar & (pca != PCA_RESERVED)
                            & (pca > 3'(k));
    end
  endgenerate

  // priority chain: each rank sees the pins taken above it
  logic [NUM_PINS-1:0] pick [NUM_RES];
  logic [NUM_PINS-1:0] taken [NUM_RES+1];
  wire [NUM_PINS-1:0] fixed_claim = pick[R_UART_TX] | pick[R_UART_RX]
                                  | pick[R_CAN_TX] | pick[R_CAN_RX];

  assign taken[0] = skip_r | fixed_claim;

  generate
    for (k = 0; k < NUM_RES; k++) begin : g_rank
      localparam int FP = fixed_pin(k);
      if (FP >= 0) begin : g_fixed
        assign pick[k] = en[k] ? (NUM_PINS'(1) << FP) : ZERO_PINS;
      end else begin : g_free
        assign pick[k] = en[k] ? lowest_one(~taken[k]) : ZERO_PINS;
      end
      assign taken[k+1] = taken[k] | pick[k];
    end
  endgenerate

  // the map is rebuilt every cycle from the live settings
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_RES; i++) route_r[i] <= ZERO_PINS;
    end else if (ce_i) begin
      for (int i = 0; i < NUM_RES; i++) route_r[i] <= pick[i];
    end
  end

  // per pin view of the map
  logic [NUM_PINS-1:0] claimed;
  logic [NUM_PINS-1:0] per_out;
  logic [NUM_PINS-1:0] per_oe;
  logic [NUM_PINS-1:0] smb_pin;

  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      logic [NUM_RES-1:0] own;
      for (k = 0; k < NUM_RES; k++) begin : g_own
        assign own[k] = route_r[k][p];
      end
      assign claimed[p] = |own;
      assign per_out[p] = |(own & periph_out_i);
      assign per_oe[p] = |(own & periph_oe_i);
      assign smb_pin[p] = own[R_SMB_SDA] | own[R_SMB_SCL];
    end
    for (k = 0; k < NUM_RES; k++) begin : g_pin_in
      assign periph_in_o[k] = pin_in_r[k];
    end
  endgenerate

  // pad cell controls
  wire [NUM_PINS-1:0] digital = in_mode_r;
  wire [NUM_PINS-1:0] drv_val = (claimed & per_out)
                              | (~claimed & gpio_out_r);
  wire [NUM_PINS-1:0] want_drv = ~claimed | per_oe;
  wire [NUM_PINS-1:0] push_pull = out_mode_r & ~smb_pin;
  wire [NUM_PINS-1:0] drv_en = {NUM_PINS{xbar}} & digital & want_drv;
  wire [NUM_PINS-1:0] oe_nxt = drv_en & (push_pull | ~drv_val);
  wire [NUM_PINS-1:0] out_nxt = drv_en & push_pull & drv_val;
  // pull-ups stay on until the crossbar settles the output modes
  wire [NUM_PINS-1:0] pullup_nxt = digital & {NUM_PINS{~wpud}}
                                 & ({NUM_PINS{~xbar}} | ~push_pull)
                                 & ~(oe_nxt & ~out_nxt);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_r <= ZERO_PINS;
      oe_r <= ZERO_PINS;
      pullup_r <= ZERO_PINS;
      rx_en_r <= ZERO_PINS;
    end else if (ce_i) begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pullup_r <= pullup_nxt;
      rx_en_r <= digital;
    end
  end

  // pads are asynchronous: three stages, accept when stages 2 and 3 agree
  wire [NUM_PINS-1:0] agree = ~(sync2_r ^ sync3_r);
  wire [NUM_PINS-1:0] stable_nxt = (agree & sync3_r) | (~agree & stable_r);

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= ZERO_PINS;
      sync2_r <= ZERO_PINS;
      sync3_r <= ZERO_PINS;
      stable_r <= ZERO_PINS;
      prev_r <= ZERO_PINS;
    end else if (ce_i) begin
      sync1_r <= pad_in_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      stable_r <= stable_nxt;
      prev_r <= stable_r;
    end
  end

  // peripherals see only their own pin through the digital receiver
  logic [NUM_RES-1:0] pin_in_nxt;
  generate
    for (k = 0; k < NUM_RES; k++) begin : g_in
      assign pin_in_nxt[k] = |(route_r[k] & pad_read);
    end
  endgenerate

  // edge events; set beats a same-cycle write-one clear
  wire [NUM_PINS-1:0] evt_set = (stable_r ^ prev_r) & in_mode_r
                              & evt_mask_r;
  wire [NUM_PINS-1:0] evt_clr = (wr && hit_ef) ? wmask : ZERO_PINS;
  wire [NUM_PINS-1:0] evt_nxt = (evt_flag_r & ~evt_clr) | evt_set;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_in_r <= '0;
      evt_flag_r <= ZERO_PINS;
      evt_pend_r <= 1'b0;
    end else if (ce_i) begin
      pin_in_r <= pin_in_nxt;
      evt_flag_r <= evt_nxt;
      evt_pend_r <= |evt_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pad_out_o = out_r;
  assign pad_oe_o = oe_r;
  assign pad_pullup_o = pullup_r;
  assign pad_rx_en_o = rx_en_r;
  assign event_pending_o = evt_pend_r;

  analog_pin_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i |=> ((~$past(in_mode_r)) & (pad_oe_o | pad_pullup_o
              | pad_rx_en_o)) == ZERO_PINS)
    else $error("analog pin has driver, pullup or receiver on");

  xbar_off_drive_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && !xbar |=> pad_oe_o == ZERO_PINS)
    else $error("pad driven while crossbar disabled");

  uart_fixed_pins_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && xbar && route_a_r[RA_UART] |=>
      route_r[R_UART_TX][PIN_UART_TX] && route_r[R_UART_RX][PIN_UART_RX])
    else $error("uart not on its fixed pins");

  can_fixed_pins_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && xbar && route_a_r[RA_CAN] |=>
      route_r[R_CAN_TX][PIN_CAN_TX] && route_r[R_CAN_RX][PIN_CAN_RX])
    else $error("can not on its fixed pins");

  smb_open_drain_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i |=> ($past(smb_pin) & pad_out_o) == ZERO_PINS)
    else $error("smbus pin driven high");

  pullup_low_off_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (pad_oe_o & ~pad_out_o & pad_pullup_o) == ZERO_PINS)
    else $error("pullup on while pin drives low");

  nss_three_wire_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i && !four_wire |=> route_r[R_SPI_NSS] == ZERO_PINS)
    else $error("slave select routed in 3-wire mode");

  skip_respected_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i |=> ($past(skip_r) & claimed & ~FIXED_MASK) == ZERO_PINS)
    else $error("skipped pin claimed by crossbar");

  event_digital_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ce_i |=> (evt_flag_r & ~$past(evt_flag_r) & ~$past(in_mode_r))
             == ZERO_PINS)
    else $error("event captured on analog pin");
endmodule // pcr_crossbar

// >>> rtl/pcr_pkg.sv
package pcr_pkg;
  localparam int NUM_PINS = 32;
  localparam int NUM_RES = 26;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int WB_SELW = 4;

  localparam logic [WB_AW-1:0] OFS_ROUTE_A = 8'h00;
  localparam logic [WB_AW-1:0] OFS_ROUTE_B = 8'h04;
  localparam logic [WB_AW-1:0] OFS_ROUTE_C = 8'h08;
  localparam logic [WB_AW-1:0] OFS_SPI_CTL = 8'h0C;
  localparam logic [WB_AW-1:0] OFS_IN_MODE = 8'h10;
  localparam logic [WB_AW-1:0] OFS_OUT_MODE = 8'h14;
  localparam logic [WB_AW-1:0] OFS_SKIP = 8'h18;
  localparam logic [WB_AW-1:0] OFS_GPIO_OUT = 8'h1C;
  localparam logic [WB_AW-1:0] OFS_PAD_READ = 8'h20;
  localparam logic [WB_AW-1:0] OFS_EVT_MASK = 8'h24;
  localparam logic [WB_AW-1:0] OFS_EVT_FLAG = 8'h28;

  localparam int RA_UART = 0;
  localparam int RA_CAN = 1;
  localparam int RA_SPI = 2;
  localparam int RA_SMB = 3;
  localparam int RA_CP0 = 4;
  localparam int RB_SYSCLK = 1;
  localparam int RB_PCA_LO = 2;
  localparam int RB_PCA_HI = 4;
  localparam int RB_ECI = 5;
  localparam int RC_LIN = 0;
  localparam int RC_XBAR = 6;
  localparam int RC_WPUD = 7;
  localparam int SS_LO = 2;
  localparam int SS_HI = 3;
  localparam logic [1:0] SS_3WIRE = 2'h0;
  localparam logic [2:0] PCA_RESERVED = 3'h7;

  // resource ranks, highest priority first
  localparam int R_UART_TX = 0;
  localparam int R_UART_RX = 1;
  localparam int R_SPI_SCK = 2;
  localparam int R_SPI_NSS = 5;
  localparam int R_SMB_SDA = 6;
  localparam int R_SMB_SCL = 7;
  localparam int R_CAN_TX = 8;
  localparam int R_CAN_RX = 9;
  localparam int R_CP0 = 10;
  localparam int R_SYSCLK = 14;
  localparam int R_CAPTURE_COMPARE_PIN_0 = 15;
  localparam int NUM_CEX = 6;
  localparam int R_ECI = 21;
  localparam int R_LIN_TX = 24;
  localparam int R_LIN_RX = 25;

  localparam int PIN_UART_TX = 4;
  localparam int PIN_UART_RX = 5;
  localparam int PIN_CAN_TX = 6;
  localparam int PIN_CAN_RX = 7;
  localparam logic [NUM_PINS-1:0] FIXED_MASK = 32'h000000F0;

  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [1:0] SS_RST = 2'h0;
  localparam logic [NUM_PINS-1:0] IN_MODE_RST = 32'hFFFFFFFF;
  localparam logic [NUM_PINS-1:0] OUT_MODE_RST = 32'h00000000;
  localparam logic [NUM_PINS-1:0] SKIP_RST = 32'h00000000;
  localparam logic [NUM_PINS-1:0] GPIO_OUT_RST = 32'hFFFFFFFF;
  localparam logic [NUM_PINS-1:0] ZERO_PINS = 32'h00000000;
  localparam logic [WB_DW-1:0] ZERO_WORD = 32'h00000000;
endpackage

// >>> testbench/pcr_pad_model.sv
`timescale 1ns/1ns
// pads as seen from outside the device; a released pad with no external drive and no pull-up
// shows the inverse of its last level, so a missing driver never passes
module pcr_pad_model (
  input wire logic core_clk_i,
  input wire logic [pcr_pkg::NUM_PINS-1:0] pad_out_i,
  input wire logic [pcr_pkg::NUM_PINS-1:0] pad_oe_i,
  input wire logic [pcr_pkg::NUM_PINS-1:0] pull_i,
  input wire logic [pcr_pkg::NUM_PINS-1:0] ext_en_i,
  input wire logic [pcr_pkg::NUM_PINS-1:0] ext_val_i,
  output logic [pcr_pkg::NUM_PINS-1:0] pad_in_o
);
  import pcr_pkg::*;
  logic [NUM_PINS-1:0] last_r = ZERO_PINS;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_oe_i[i])
        pad_in_o[i] = pad_out_i[i];
      else if (ext_en_i[i])
        pad_in_o[i] = ext_val_i[i];
      else if (pull_i[i])
        pad_in_o[i] = 1'b1;
      else
        pad_in_o[i] = ~last_r[i];
    end
  end
  always_ff @(posedge core_clk_i) begin
    last_r <= pad_in_o;
  end
endmodule // pcr_pad_model

// >>> testbench/test_priority_crossbar_pin_router.sv
`timescale 1ns/1ns
module test_priority_crossbar_pin_router;
  import pcr_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i, ce_i, cyc, stb, we, ack, evt;
  logic [WB_AW-1:0] adr;
  logic [WB_SELW-1:0] sel;
  logic [WB_DW-1:0] wdat, rdat, rd;
  logic [NUM_RES-1:0] p_out, p_oe, p_in;
  logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, pull, rx_en, ext_en, ext_val;
  int num_errors = 0;
  int tests_run = 0;
  int pin_t[9] = '{0, 3, 4, 8, 6, 7, 9, 11, 12};
  int rank_t[9] = '{2, 3, 4, 5, 8, 9, 15, 17, -1};
  logic [31:0] m;
  logic [WB_SELW-1:0] wsel = 4'hF;

  always #20 core_clk_i = ~core_clk_i;

  pcr_crossbar uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .periph_out_i(p_out), .periph_oe_i(p_oe),
    .periph_in_o(p_in), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .pad_pullup_o(pull), .pad_rx_en_o(rx_en),
    .event_pending_o(evt));
  pcr_pad_model pad0 (.core_clk_i(core_clk_i), .pad_out_i(pad_out),
    .pad_oe_i(pad_oe), .pull_i(pull), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_in_o(pad_in));

  task end_of_test;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until ack is sampled, then releases it
  task wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    // no cycle count is assumed; only the watchdog ends a lost answer
    @(posedge core_clk_i);
    while (ack !== 1'b1)
      @(posedge core_clk_i);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rdchk(input logic [WB_AW-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, ZERO_WORD);
    chk(rd, exp);
  endtask

  // synchroniser plus routing pipeline fit well inside eight edges
  task settle;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    end_of_test;
  end

  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
    p_out = '0;
    p_oe = '0;
    ext_en = ZERO_PINS;
    ext_val = ZERO_PINS;
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    settle;
    chk(rx_en, 32'hFFFFFFFF);
    chk(pad_oe, 32'h00000000);
    chk(pull, 32'hFFFFFFFF);
    rdchk(OFS_IN_MODE, 32'hFFFFFFFF);
    rdchk(OFS_ROUTE_C, 32'h00000000);
    rdchk(8'h3C, 32'h00000000);
    wb(1'b1, OFS_OUT_MODE, 32'hFFFFFFFF);
    wb(1'b1, OFS_ROUTE_A, 32'h00000001);
    wb(1'b1, OFS_GPIO_OUT, 32'h00000000);
    settle;
    chk(pad_oe, 32'h00000000);
    wb(1'b1, OFS_SKIP, 32'h00000026);
    ext_en <= 32'hFFFFFFFF;
    wb(1'b1, OFS_SPI_CTL, 32'h00000004);
    wb(1'b1, OFS_ROUTE_A, 32'h00000006);
    wb(1'b1, OFS_ROUTE_B, 32'h0000000C);
    wb(1'b1, OFS_ROUTE_C, 32'h00000040);
    settle;
    chk(pad_oe, 32'hFFFFF026);
    for (int k = 0; k < 9; k++) begin
      @(posedge core_clk_i);
      ext_val <= 32'h1 << pin_t[k];
      settle;
      m = (rank_t[k] < 0) ? 32'h0 : (32'h1 << rank_t[k]);
      chk(32'(p_in), m);
    end
    wb(1'b1, OFS_SPI_CTL, 32'h00000000);
    settle;
    chk(pad_oe, 32'hFFFFF826);
    wb(1'b1, OFS_SKIP, 32'h00000036);
    wb(1'b1, OFS_ROUTE_A, 32'h00000007);
    settle;
    chk(pad_oe, 32'hFFFFF006);
    wb(1'b1, OFS_SKIP, 32'h00000000);
    wb(1'b1, OFS_ROUTE_A, 32'h00000000);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, OFS_ROUTE_B, 32'(c) << 2);
      settle;
      m = (c == 0 || c == 7) ? 32'h0 : ((32'h1 << c) - 32'h1);
      chk(pad_oe, ~m);
    end
    wb(1'b1, OFS_ROUTE_B, 32'h00000000);
    wb(1'b1, OFS_GPIO_OUT, 32'h00000004);
    wb(1'b1, OFS_ROUTE_A, 32'h00000008);
    p_oe <= 26'h00000C0;
    p_out <= 26'h00000C0;
    ext_en <= ZERO_PINS;
    settle;
    chk(pad_oe & 32'h3, 32'h0);
    chk(pull & 32'h7, 32'h3);
    chk(pad_out & pad_oe & 32'h4, 32'h4);
    @(posedge core_clk_i);
    p_out <= 26'h0000000;
    settle;
    chk(pad_oe & 32'h3, 32'h3);
    chk(pad_out & 32'h3, 32'h0);
    chk(pull & 32'h3, 32'h0);
    wb(1'b1, OFS_ROUTE_C, 32'h000000C0);
    p_out <= 26'h00000C0;
    settle;
    chk(pull & 32'h3, 32'h0);
    wb(1'b1, OFS_ROUTE_C, 32'h00000040);
    wb(1'b1, OFS_IN_MODE, 32'hFFFFFFF7);
    wb(1'b1, OFS_OUT_MODE, 32'hFFFFFEFF);
    wb(1'b1, OFS_SKIP, 32'h00000008);
    wb(1'b1, OFS_GPIO_OUT, 32'hFFFFFFFF);
    ext_en <= 32'h00000108;
    ext_val <= 32'h00000008;
    settle;
    chk(rx_en & 32'h8, 32'h0);
    chk((pull | pad_oe) & 32'h8, 32'h0);
    wb(1'b0, OFS_PAD_READ, ZERO_WORD);
    chk(rd & 32'h10C, 32'h4);
    wb(1'b1, OFS_EVT_MASK, 32'h00000108);
    wb(1'b1, OFS_EVT_FLAG, 32'hFFFFFFFF);
    ext_val <= 32'h00000108;
    settle;
    chk({31'h0, evt}, 32'h1);
    wb(1'b1, OFS_EVT_FLAG, 32'hFFFFFFFF);
    ext_val <= 32'h00000100;
    settle;
    chk({31'h0, evt}, 32'h0);
    // clock enable low freezes the synchroniser and the flags
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    ext_val <= 32'h00000008;
    settle;
    chk({31'h0, evt}, 32'h0);
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    settle;
    chk({31'h0, evt}, 32'h1);
    wb(1'b1, OFS_ROUTE_A, 32'h00000000);
    wb(1'b1, OFS_ROUTE_C, 32'h00000041);
    settle;
    chk(pad_oe, 32'hFFFFFEF4);
    wsel = 4'hE;
    wb(1'b1, OFS_ROUTE_C, 32'h00000000);
    wsel = 4'hF;
    rdchk(OFS_ROUTE_C, 32'h00000041);
    end_of_test;
  end
endmodule // test_priority_crossbar_pin_router
